// >>> pkg/spi_port_pkg.sv
// Operation
// - every transfer shifts exactly 8 bits out and 8 bits in together
// - data moves most significant bit first, both directions, master and slave
// - only the master drives the serial clock and starts exchanges
// - after bit eight the byte goes to the buffer, then full and irq flags set
// - buffer write during a transfer is dropped, shift register untouched, collision flag set
// - collision flag stays set until software clears it
// - reading the last unread byte from the buffer clears the buffer-full flag
// - in master mode a buffer write with room in the buffer starts the transfer at once
// - shift register is reachable only through the buffer
// - clearing the enable resets the port, setting it restarts operation
// - enabled master takes over pins, drives clock and data out, samples data in
// - master rate is system clock over 4, 16, 64 or timer output over 2
// - polarity bit picks the resting level of the serial clock
// - edge select set means output bit valid before the partner's sampling edge
// - sample-phase bit samples input at middle or end of the bit time
// - master in sleep freezes the transfer and resumes after wake-up
// - receive-only master may disable data out but keeps shifting data in
// - slave shifts one bit per external clock pulse, never chooses transfer timing
// - slave byte completing while the buffer is still full sets overflow, stops traffic
// - in slave-select mode a high select holds reset and floats data out
// - any port reset returns the bit counter to zero
package spi_port_pkg;
    localparam int         BYTE_W     = 8;
    localparam int         MODE_W     = 4;
    localparam int         FIFO_DEPTH = 16;
    localparam int         HALF_CNT_W = 6;
    localparam logic [3:0] MODE_DIV4  = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_TIMER = 4'h3;
    localparam logic [3:0] MODE_SL_SS = 4'h4;
    localparam logic [3:0] MODE_SL_NO = 4'h5;
    // system clocks per half period of the serial clock
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam logic [4:0] HALF_FIRST = 5'h00;
    localparam logic [4:0] HALF_END   = 5'h10;
    typedef enum logic {ST_IDLE, ST_SHIFT} state_t;
endpackage

// >>> rtl/byte_fifo.sv
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = spi_port_pkg::BYTE_W,
    parameter int DEPTH = spi_port_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst,       // synchronous reset
    input  wire logic             in_valid,  // push request
    output logic                  in_ready,  // room for one more word
    input  wire logic [WIDTH-1:0] in_data,   // word pushed
    output logic                  out_valid, // head word present
    input  wire logic             out_ready, // pop request
    output logic      [WIDTH-1:0] out_data   // head word
);
    import spi_port_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = count_ff != (PW+1)'(DEPTH);
    assign out_valid = count_ff != '0;
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_ready && out_valid;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + PW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + PW'(1);
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// >>> rtl/sck_rate_gen.sv
`timescale 1ns/1ns
module sck_rate_gen #(
    parameter int CNT_W = 6
) (
    input  wire logic       clk,        // system clock
    input  wire logic       rst,        // synchronous reset
    input  wire logic       clear,      // restart the half period
    input  wire logic       hold,       // freeze the count (sleep)
    input  wire logic [1:0] rate_sel,   // low bits of the mode field
    input  wire logic       timer_tick, // one-cycle timer output pulse
    output logic            tick        // one half period elapsed
);
    import spi_port_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] limit;

    always_comb begin
        case (rate_sel)
            MODE_DIV4[1:0]:  limit = CNT_W'(HALF_DIV4);
            MODE_DIV16[1:0]: limit = CNT_W'(HALF_DIV16);
            default:         limit = CNT_W'(HALF_DIV64);
        endcase
    end

    // timer rate: each timer pulse is a half period, giving timer over 2
    assign tick = !clear && !hold && ((rate_sel == MODE_TIMER[1:0]) ? timer_tick
                                      : (cnt_ff == limit - CNT_W'(1)));

    always_ff @(posedge clk) begin
        if (rst || clear || tick) begin
            cnt_ff <= '0;
        end else if (!hold && rate_sel != MODE_TIMER[1:0]) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end
endmodule

// >>> rtl/sync_serial_port.sv
`timescale 1ns/1ns
module sync_serial_port (
    input  wire logic                            CLOCK,              // system clock
    input  wire logic                            RESET,              // sync reset, high
    input  wire logic                            PORT_ENABLE,        // port enable bit
    input  wire logic [spi_port_pkg::MODE_W-1:0] PORT_MODE,          // port mode field
    input  wire logic                            CLOCK_IDLE_POL,     // resting clock level
    input  wire logic                            CLOCK_EDGE_SEL,     // data valid before edge
    input  wire logic                            INPUT_SAMPLE_PHASE, // 1 samples at end
    input  wire logic                            RX_ONLY,            // master data out off
    input  wire logic                            SLEEP,              // core clock halted
    input  wire logic                            TIMER_TICK,         // timer output pulse
    input  wire logic                            BUF_WR_STROBE,      // write the buffer
    input  wire logic [spi_port_pkg::BYTE_W-1:0] BUF_WR_DATA,        // byte written
    input  wire logic                            BUF_RD_STROBE,      // read the buffer
    output logic      [spi_port_pkg::BYTE_W-1:0] BUF_RD_DATA,        // oldest received byte
    output logic                                 BUFFER_FULL_FLAG,   // unread byte waiting
    input  wire logic                            WRITE_COLLISION_FLAG_CLEAR,         // clear collision flag
    input  wire logic                            OVF_CLEAR,          // clear overflow flag
    input  wire logic                            IRQ_CLEAR,          // clear irq flag
    output logic                                 WRITE_COLLISION_FLAG, // write refused
    output logic                                 RX_OVERFLOW_FLAG,   // slave byte lost
    output logic                                 PORT_IRQ_FLAG,      // byte completed
    output logic                                 XFER_BUSY,          // transfer in progress
    input  wire logic                            SCK_IN,             // serial clock pin in
    output logic                                 SCK_OUT,            // serial clock pin out
    output logic                                 SCK_OE,             // serial clock drive
    input  wire logic                            SERIAL_IN_PIN,                // serial_in_pin
    output logic                                 SDO_OUT,            // serial_out_pin level
    output logic                                 SDO_OE,             // serial_out_pin drive
    input  wire logic                            SS_N                // slave select, low
);
    import spi_port_pkg::*;

    function automatic logic mode_is_master(input logic [MODE_W-1:0] m);
        return m <= MODE_TIMER;
    endfunction

    function automatic logic mode_is_slave(input logic [MODE_W-1:0] m);
        return m == MODE_SL_SS || m == MODE_SL_NO;
    endfunction

    state_t            state_ff;
    logic [BYTE_W-1:0] shift_reg_ff;
    logic [2:0]        bit_cnt_ff;
    logic [4:0]        half_ff;
    logic              sck_ff;
    logic              sck_prev_ff;
    logic              sample_ff;
    logic              s_active_ff;
    logic              write_collision_flag_ff;
    logic              ovf_ff;
    logic              irq_ff;

    logic              is_master;
    logic              is_slave;
    logic              ss_hold;
    logic              port_reset;
    logic              slave_run;
    logic              busy;
    logic              tick;
    logic              m_tick;
    logic              m_shift;
    logic              m_mid;
    logic              sck_edge;
    logic              lead;
    logic              trail;
    logic              s_last_trail;
    logic              s_shift;
    logic              shift_ev;
    logic              mid_ev;
    logic              in_bit;
    logic              done_ev;
    logic [BYTE_W-1:0] rx_byte;
    logic              wr_ok;
    logic              collision;
    logic              fifo_in_ready;
    logic              push;

    assign is_master  = PORT_ENABLE && mode_is_master(PORT_MODE);
    assign is_slave   = PORT_ENABLE && mode_is_slave(PORT_MODE);
    assign ss_hold    = PORT_ENABLE && PORT_MODE == MODE_SL_SS && SS_N;
    assign port_reset = !PORT_ENABLE || ss_hold;
    // overflow parks the slave until software clears it
    assign slave_run  = is_slave && !ss_hold && !ovf_ff;
    assign busy       = (is_master && state_ff == ST_SHIFT) || s_active_ff;

    sck_rate_gen #(
        .CNT_W      (HALF_CNT_W)
    ) u_rate (
        .clk        (CLOCK),
        .rst        (RESET),
        .clear      (!(is_master && state_ff == ST_SHIFT)),
        .hold       (SLEEP),
        .rate_sel   (PORT_MODE[1:0]),
        .timer_tick (TIMER_TICK),
        .tick       (tick)
    );

    // master: half periods 0..15 toggle the clock; half 16 only ends the last bit time
    assign m_tick  = is_master && state_ff == ST_SHIFT && tick && !SLEEP;
    assign m_shift = m_tick && (CLOCK_EDGE_SEL ? half_ff[0]
                                : (!half_ff[0] && half_ff != HALF_FIRST));
    assign m_mid   = m_tick && (CLOCK_EDGE_SEL ? (!half_ff[0] && half_ff != HALF_END)
                                : half_ff[0]);

    // slave: pin is synchronous, edges seen by comparing with last sample
    assign sck_edge     = slave_run && SCK_IN != sck_prev_ff;
    assign lead         = sck_edge && sck_prev_ff == CLOCK_IDLE_POL;
    assign trail        = sck_edge && !lead;
    assign s_last_trail = trail && !CLOCK_EDGE_SEL && bit_cnt_ff == LAST_BIT;
    assign s_shift      = CLOCK_EDGE_SEL ? trail
                          : ((lead && s_active_ff) || s_last_trail);

    assign shift_ev = m_shift || s_shift;
    assign mid_ev   = m_mid || (sck_edge && (CLOCK_EDGE_SEL ? lead : trail));
    // end-of-bit sampling takes the pin on the shifting edge itself
    assign in_bit   = ((m_shift && INPUT_SAMPLE_PHASE) || s_last_trail) ? SERIAL_IN_PIN
                      : sample_ff;
    assign rx_byte  = {shift_reg_ff[BYTE_W-2:0], in_bit};
    assign done_ev  = shift_ev && bit_cnt_ff == LAST_BIT;
    assign push     = done_ev && fifo_in_ready;

    // master start also waits for room, so a finished byte always has a slot
    assign wr_ok     = BUF_WR_STROBE && PORT_ENABLE && !busy && fifo_in_ready;
    assign collision = BUF_WR_STROBE && PORT_ENABLE && !wr_ok;

    byte_fifo #(
        .WIDTH     (BYTE_W),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rst       (RESET),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_byte),
        .out_valid (BUFFER_FULL_FLAG),
        .out_ready (BUF_RD_STROBE),
        .out_data  (BUF_RD_DATA)
    );

    // software reaches the shift register only by a buffer write
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            shift_reg_ff <= '0;
        end else if (wr_ok) begin
            shift_reg_ff <= BUF_WR_DATA;
        end else if (shift_ev) begin
            shift_reg_ff <= rx_byte;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET || port_reset) begin
            bit_cnt_ff <= '0;
        end else if (wr_ok && is_master) begin
            bit_cnt_ff <= '0;
        end else if (shift_ev) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET || !is_master) begin
            state_ff <= ST_IDLE;
            half_ff  <= HALF_FIRST;
            sck_ff   <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (wr_ok) begin
                        state_ff <= ST_SHIFT;
                        half_ff  <= HALF_FIRST;
                        sck_ff   <= 1'b0;
                    end
                end
                ST_SHIFT: begin
                    if (done_ev) begin
                        state_ff <= ST_IDLE;
                        sck_ff   <= 1'b0;
                    end else if (m_tick) begin
                        half_ff <= half_ff + 5'h01;
                        if (half_ff != HALF_END) begin
                            sck_ff <= !sck_ff;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            sample_ff <= 1'b0;
        end else if (mid_ev) begin
            sample_ff <= SERIAL_IN_PIN;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            // rest level, so an idle-high pin shows no false edge after reset
            sck_prev_ff <= CLOCK_IDLE_POL;
        end else begin
            sck_prev_ff <= SCK_IN;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET || !slave_run || done_ev) begin
            s_active_ff <= 1'b0;
        end else if (sck_edge) begin
            s_active_ff <= 1'b1;
        end
    end

    // each flag: a set in the same cycle as its clear wins
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            write_collision_flag_ff <= 1'b0;
        end else if (collision) begin
            write_collision_flag_ff <= 1'b1;
        end else if (WRITE_COLLISION_FLAG_CLEAR) begin
            write_collision_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ovf_ff <= 1'b0;
        end else if (done_ev && is_slave && !fifo_in_ready) begin
            ovf_ff <= 1'b1;
        end else if (OVF_CLEAR) begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            irq_ff <= 1'b0;
        end else if (push) begin
            irq_ff <= 1'b1;
        end else if (IRQ_CLEAR) begin
            irq_ff <= 1'b0;
        end
    end

    assign WRITE_COLLISION_FLAG = write_collision_flag_ff;
    assign RX_OVERFLOW_FLAG     = ovf_ff;
    assign PORT_IRQ_FLAG        = irq_ff;
    assign XFER_BUSY            = busy;
    assign SCK_OE               = is_master;
    assign SCK_OUT              = is_master && (sck_ff ^ CLOCK_IDLE_POL);
    assign SDO_OUT              = shift_reg_ff[BYTE_W-1];
    assign SDO_OE               = (is_master && !RX_ONLY)
                                  || (is_slave && !ss_hold);

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    sequence s_master_start;
        is_master && state_ff == ST_IDLE && wr_ok;
    endsequence

    sequence s_div4_tick;
        is_master && PORT_MODE == MODE_DIV4 && m_tick && !done_ev;
    endsequence

    chk_write_collision_flag_sticky_hold: assert property (write_collision_flag_ff && !WRITE_COLLISION_FLAG_CLEAR |=> write_collision_flag_ff)
        else $error("collision flag dropped without a clear");
    chk_collision_sets_flag: assert property (
        BUF_WR_STROBE && busy && PORT_ENABLE |=> write_collision_flag_ff)
        else $error("write during transfer did not flag a collision");
    chk_collision_keeps_shift: assert property (
        BUF_WR_STROBE && busy && !shift_ev |=> $stable(shift_reg_ff))
        else $error("refused write disturbed the shift register");
    chk_done_sets_flags: assert property (push |=> irq_ff && BUFFER_FULL_FLAG)
        else $error("completed byte did not raise full and irq");
    chk_port_reset_count: assert property (port_reset |=> bit_cnt_ff == '0)
        else $error("bit counter not cleared by port reset");
    chk_ss_float_out: assert property (ss_hold |-> !SDO_OE ##1 !s_active_ff)
        else $error("held slave still drives data out");
    chk_sck_rest_level: assert property (
        is_master && state_ff == ST_IDLE |-> SCK_OUT == CLOCK_IDLE_POL)
        else $error("idle clock not at resting level");
    chk_master_write_start: assert property (
        s_master_start |=> state_ff == ST_SHIFT && XFER_BUSY)
        else $error("master write did not start a transfer");
    chk_sleep_freezes_xfer: assert property (
        is_master && SLEEP && state_ff == ST_SHIFT |=>
        $stable(half_ff) && $stable(shift_reg_ff) && $stable(sck_ff))
        else $error("master transfer moved during sleep");
    chk_msb_first_out: assert property (wr_ok |=> SDO_OUT == $past(BUF_WR_DATA[BYTE_W-1]))
        else $error("loaded byte does not present its top bit");
    chk_ovf_stops_slave: assert property (ovf_ff && is_slave |=> !s_active_ff && !push)
        else $error("slave kept shifting after overflow");
    chk_slave_no_clock: assert property (!is_master |-> !SCK_OE)
        else $error("non-master drives the serial clock");
    chk_div4_tick_rate: assert property (
        s_div4_tick ##1 (!SLEEP && PORT_MODE == MODE_DIV4 && is_master)
        ##1 (!SLEEP && PORT_MODE == MODE_DIV4 && is_master) |-> m_tick)
        else $error("divide-by-4 half period is not two clocks");
endmodule

// >>> testbench/spi_peer_model.sv
`timescale 1ns/1ns
module spi_peer_model (
    input  wire logic       sck,       // serial clock from the master
    input  wire logic       idle_pol,  // resting clock level
    input  wire logic       edge_sel,  // 1 samples on leading edge, 0 on trailing
    input  wire logic       mosi,      // data from the master
    input  wire logic [7:0] load_byte, // byte sent next
    input  wire logic       load,      // restart with load_byte
    output logic            miso,      // data to the master
    output logic      [7:0] got_byte   // last bits received
);
    logic [7:0] tx_sr;
    logic       seen;

    initial begin
        tx_sr = 8'h00;
        got_byte = 8'h00;
        seen = 1'b0;
    end
    // the peer only listens to the clock, it never drives it
    always @(posedge load) begin
        tx_sr = load_byte;
        seen = 1'b0;
    end
    // the top bit stands from the load, so no shift comes before the first sample
    always @(sck) begin
        if ((sck !== idle_pol) == edge_sel) begin
            got_byte = {got_byte[6:0], mosi}; // msb first
            seen = 1'b1;
        end else if (seen) begin
            tx_sr = {tx_sr[6:0], ~tx_sr[0]}; // inverse fill, a stale bit never looks valid
        end
    end
    assign miso = tx_sr[7];
endmodule

// >>> testbench/sync_serial_port_bench.sv
`timescale 1ns/1ns
module sync_serial_port_bench;
    import spi_port_pkg::*;
    // cfg bits: polarity, receive-only, edge select, sample phase
    typedef struct packed {logic [3:0] mode; logic [3:0] cfg; logic [7:0] tx; logic [7:0] pb;} row_t;
    row_t rows [6] = '{{MODE_DIV4, 4'b0010, 8'ha5, 8'h3c}, {MODE_DIV16, 4'b1001, 8'h81, 8'h7e},
                       {MODE_DIV64, 4'b0111, 8'h5a, 8'hc3}, {MODE_TIMER, 4'b1000, 8'h0f, 8'hf0},
                       {MODE_SL_NO, 4'b0010, 8'h69, 8'h96}, {MODE_SL_SS, 4'b1000, 8'hc5, 8'h3a}};
    logic       clock = 0, reset = 1, en = 1, pol = 0, rxo = 0, sleep = 0, tmr = 0;
    logic       wr = 0, rd = 0, wclr = 0, iclr = 0, oclr = 0, peer_load = 0;
    logic       cke = 1, input_sample_phase = 0, sckin = 0, ssn = 0;
    logic [3:0] mode = MODE_DIV4;
    logic [7:0] wdata = 8'h00, peer_byte = 8'h00, rdata, got;
    logic       bf, write_collision_flag, ovf, irq, busy, sck, sck_oe, serial_in_pin, serial_out_pin, sdo_oe, s;
    wire        pclk = sck_oe ? sck : sckin;
    int         num_errors = 0, cmp_count = 0;

    always #50 clock = ~clock;
    always @(posedge clock) tmr <= #10 ~tmr;

    sync_serial_port DUT (.CLOCK(clock), .RESET(reset), .PORT_ENABLE(en), .PORT_MODE(mode),
        .CLOCK_IDLE_POL(pol), .CLOCK_EDGE_SEL(cke), .INPUT_SAMPLE_PHASE(input_sample_phase), .RX_ONLY(rxo),
        .SLEEP(sleep), .TIMER_TICK(tmr), .BUF_WR_STROBE(wr), .BUF_WR_DATA(wdata),
        .BUF_RD_STROBE(rd), .BUF_RD_DATA(rdata), .BUFFER_FULL_FLAG(bf), .WRITE_COLLISION_FLAG_CLEAR(wclr),
        .OVF_CLEAR(oclr), .IRQ_CLEAR(iclr), .WRITE_COLLISION_FLAG(write_collision_flag), .RX_OVERFLOW_FLAG(ovf),
        .PORT_IRQ_FLAG(irq), .XFER_BUSY(busy), .SCK_IN(sckin), .SCK_OUT(sck), .SCK_OE(sck_oe),
        .SERIAL_IN_PIN(serial_in_pin), .SDO_OUT(serial_out_pin), .SDO_OE(sdo_oe), .SS_N(ssn));
    spi_peer_model peer (.sck(pclk), .idle_pol(pol), .edge_sel(cke), .mosi(sdo_oe ? serial_out_pin : ~serial_out_pin),
        .load_byte(peer_byte), .load(peer_load), .miso(serial_in_pin), .got_byte(got));

    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #10;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // buffer loaded before any clock edge reaches the peer
    task automatic start(input logic [7:0] tx, input logic [7:0] pb);
        peer_byte = pb;
        peer_load = 1;
        wdata = tx;
        wr = 1;
        step();
        wr = 0;
        peer_load = 0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            step();
            n++;
        end
        if (n >= 3000) num_errors++;
    endtask
    // stands in for an outside master: two system clocks per half period
    task automatic sclk(input int n = 16);
        repeat (n) begin
            sckin = ~sckin;
            step(2);
        end
    endtask
    task automatic pop(input logic [7:0] exp);
        check(rdata, exp); // oldest byte first
        rd = 1;
        iclr = 1;
        step();
        rd = 0;
        iclr = 0;
    endtask
    task automatic conclude();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #2000000;
        num_errors++;
        conclude();
    end

    initial begin
        step(5);
        reset = 0;
        check({bf, write_collision_flag, ovf, irq, busy}, 5'h00);
        foreach (rows[i]) begin
            {mode, sckin} = {4'hf, rows[i].cfg[3]}; // park the port so the pin move is no edge
            step();
            mode = rows[i].mode;
            {pol, rxo, cke, input_sample_phase} = rows[i].cfg;
            step(2);
            start(rows[i].tx, rows[i].pb);
            check({busy, sck_oe, sdo_oe}, {{2{mode <= MODE_TIMER}}, ~rxo});
            if (mode <= MODE_TIMER) wait_done();
            else sclk();
            check({bf, irq, pclk}, {2'b11, pol});
            check(rdata, rows[i].pb); // input taken at the set rate
            if (!rxo) check(got, rows[i].tx); // all 8 bits, msb first
            pop(rows[i].pb);
            check({bf, irq}, 2'b00); // read clears full
            $display("row %0d done", i);
        end
        {mode, pol, rxo, cke, input_sample_phase, sckin} = {MODE_DIV4, 5'b00100};
        step(2);
        start(8'h3c, 8'hc3);
        step(3);
        wdata = 8'hff;
        wr = 1;
        step();
        wr = 0; // the peer keeps its byte, unlike start()
        check(write_collision_flag, 1'b1);
        wait_done();
        check(got, 8'h3c); // shift register untouched
        pop(8'hc3);
        check(write_collision_flag, 1'b1); // sticky
        wclr = 1;
        step();
        wclr = 0;
        check(write_collision_flag, 1'b0);
        $display("collision done");
        for (int i = 0; i < 16; i++) begin
            start(i[7:0], 8'ha0 + i[7:0]);
            wait_done();
        end
        start(8'h11, 8'h22);
        check({write_collision_flag, busy}, 2'b10); // full buffer refuses
        for (int i = 0; i < 16; i++) pop(8'ha0 + i[7:0]);
        check(bf, 1'b0);
        $display("fill done");
        start(8'h66, 8'h99);
        step(6);
        sleep = 1;
        s = sck;
        step(20);
        check({busy, sck}, {1'b1, s}); // frozen in sleep
        sleep = 0;
        wait_done();
        check(got, 8'h66); // resumes where it stopped
        pop(8'h99);
        start(8'h12, 8'h34);
        step(5);
        en = 0;
        step();
        check(busy, 1'b0);
        en = 1;
        step();
        start(8'h96, 8'h69);
        wait_done();
        check(got, 8'h96); // counter restarted at zero
        pop(8'h69);
        $display("sleep and abort done");
        {mode, pol, cke, sckin} = {MODE_SL_SS, 3'b010};
        step(2);
        for (int i = 0; i < 17; i++) begin
            start(i[7:0], 8'h50 + i[7:0]);
            sclk();
        end
        check({ovf, bf}, 2'b11); // byte lost on a full buffer
        sckin = 1;
        step(2);
        check(busy, 1'b0); // traffic stopped
        sckin = 0;
        step(2);
        for (int i = 0; i < 16; i++) pop(8'h50 + i[7:0]);
        oclr = 1;
        step();
        oclr = 0;
        check(ovf, 1'b0);
        start(8'h77, 8'h88);
        sclk(6);
        ssn = 1;
        step();
        check({sdo_oe, busy}, 2'b00); // select high floats data out, holds reset
        ssn = 0;
        start(8'hc5, 8'h3a);
        sclk();
        check(got, 8'hc5);
        pop(8'h3a); // bit counter restarted by the select
        $display("slave done");
        conclude();
    end
endmodule
